// File: src/wem_regs.svh
// register offsets, field positions, reset values and timing constants for the waveform monitor
`ifndef WEM_REGS_SVH
`define WEM_REGS_SVH

`define WEM_OFF_GAIN 8'h00
`define WEM_OFF_MEASMODE 8'h04
`define WEM_OFF_WAVEMODE 8'h08
`define WEM_OFF_LINEMODE 8'h0C
`define WEM_OFF_THRESH 8'h10
`define WEM_OFF_MASK 8'h14
`define WEM_OFF_STATUS 8'h18
`define WEM_OFF_STATUS_CLR 8'h1C
`define WEM_OFF_WAVE_HI 8'h20
`define WEM_OFF_WAVE_MID 8'h24
`define WEM_OFF_WAVE_LO 8'h28
`define WEM_OFF_CUR_PEAK 8'h2C
`define WEM_OFF_VOLT_PEAK 8'h30
`define WEM_OFF_PEAKCYC 8'h34

`define WEM_GAIN_INTEG_BIT 7
`define WEM_MODE_OVERCUR_LSB 5
`define WEM_MODE_PEAK_LSB 2
`define WEM_WAV_SRC_LSB 2
`define WEM_WAV_RATE_LSB 5
`define WEM_ST_OVERCUR_BIT 15
`define WEM_ST_CROSS_LSB 9
`define WEM_ST_READY_BIT 16
`define WEM_WAV_SRC_VOLT 3'b001
`define WEM_PEAK_LSB 14
`define WEM_PEAK_MSB 21
`define WEM_PEAKCYC_RESET 8'h04
`define WEM_LPF_SHIFT 5
`define WEM_RATE_BASE_DIV 16'h03C0
`define WEM_AXI_OKAY 2'b00
`define WEM_AXI_SLVERR 2'b10

`endif

// File: src/wem_pkg.sv
// types shared by the waveform monitor
package wem_pkg;
  typedef struct packed {
    logic [23:0] current;
    logic [15:0] voltage;
    logic valid;
  } wem_sample_type;

  typedef enum logic [1:0] {
    WEM_RD_IDLE = 2'b00,
    WEM_RD_RESP = 2'b01
  } wem_rd_state_type;
endpackage

// File: src/wem_monitor.sv
// three-phase waveform, peak, overcurrent and zero-crossing monitor with AXI4-Lite registers
`timescale 1ns/100ps
`include "wem_regs.svh"
module wem_monitor import wem_pkg::*; #(
  parameter int PHASES = 3,
  parameter int RATE_BASE_DIV = `WEM_RATE_BASE_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire wem_sample_type adc_a,
  input wire wem_sample_type adc_b,
  input wire wem_sample_type adc_c,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic integrator_on,
  output logic [PHASES-1:0] crossing_pulse,
  output logic irq_n
);
  wem_sample_type adc [PHASES];
  assign adc[0] = adc_a;
  assign adc[1] = adc_b;
  assign adc[2] = adc_c;

  logic [7:0] gain_reg;
  logic [7:0] measurement_mode_reg;
  logic [7:0] waveform_mode_reg;
  logic [7:0] line_cycle_mode_reg;
  logic [7:0] overcurrent_threshold;
  logic [7:0] peak_cycles_reg;
  logic [16:0] mask_reg;
  logic [16:0] status_reg;
  logic [16:0] status_set;
  logic status_clear;
  logic [23:0] waveform_result;
  logic [7:0] current_peak_value;
  logic [7:0] voltage_peak_value;

  // lowpass and crossing detection per phase
  logic signed [15:0] lp_reg [PHASES];
  logic [PHASES-1:0] lp_pos_reg;
  logic [PHASES-1:0] cross_rise;
  logic [7:0] iabs [PHASES];
  logic [7:0] vabs [PHASES];
  logic [PHASES-1:0] over_hit;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : gen_phase
      logic signed [15:0] vin;
      logic signed [15:0] lp_next;
      logic signed [23:0] cur;
      logic [23:0] cur_mag;
      logic [15:0] v_mag;
      assign vin = $signed(adc[g].voltage);
      // raw voltage feeds this filter and the voltage peak magnitude; current paths tap adc directly
      assign lp_next = lp_reg[g] + ((vin - lp_reg[g]) >>> `WEM_LPF_SHIFT);
      assign cur = $signed(adc[g].current);
      assign cur_mag = cur[23] ? 24'(-cur) : adc[g].current;
      assign v_mag = vin[15] ? 16'(-vin) : adc[g].voltage;
      assign iabs[g] = cur_mag[`WEM_PEAK_MSB:`WEM_PEAK_LSB];
      assign vabs[g] = v_mag[13:6];
      assign over_hit[g] = measurement_mode_reg[`WEM_MODE_OVERCUR_LSB + g] && adc[g].valid
        && (iabs[g] > overcurrent_threshold);
      assign cross_rise[g] = adc[g].valid && !lp_pos_reg[g] && !lp_next[15];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lp_reg[g] <= 16'h0000;
          lp_pos_reg[g] <= 1'b0;
        end else if (adc[g].valid) begin
          lp_reg[g] <= lp_next;
          lp_pos_reg[g] <= !lp_next[15];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crossing_pulse <= '0;
    end else begin
      crossing_pulse <= cross_rise;
    end
  end

  // line-cycle counting from rising crossings of the selected phases
  logic [7:0] half_count_reg;
  logic [7:0] ipk_run_reg;
  logic [7:0] vpk_run_reg;
  logic half_tick;
  logic window_end;
  logic [7:0] ipk_cand;
  logic [7:0] vpk_cand;
  assign half_tick = |(cross_rise & line_cycle_mode_reg[PHASES-1:0]);
  assign window_end = half_tick && (half_count_reg + 8'h01 >= peak_cycles_reg);

  always_comb begin
    ipk_cand = ipk_run_reg;
    vpk_cand = vpk_run_reg;
    for (int p = 0; p < PHASES; p++) begin
      // each peak tracks its own maximum, so results may come from different phases
      if (measurement_mode_reg[`WEM_MODE_PEAK_LSB + p] && adc[p].valid) begin
        if (iabs[p] > ipk_cand) ipk_cand = iabs[p];
        if (vabs[p] > vpk_cand) vpk_cand = vabs[p];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_count_reg <= 8'h00;
      ipk_run_reg <= 8'h00;
      vpk_run_reg <= 8'h00;
      current_peak_value <= 8'h00;
      voltage_peak_value <= 8'h00;
    end else if (window_end) begin
      half_count_reg <= 8'h00;
      ipk_run_reg <= 8'h00;
      vpk_run_reg <= 8'h00;
      current_peak_value <= ipk_cand;
      voltage_peak_value <= vpk_cand;
    end else begin
      if (half_tick) half_count_reg <= half_count_reg + 8'h01;
      ipk_run_reg <= ipk_cand;
      vpk_run_reg <= vpk_cand;
    end
  end

  // waveform sampling: rate divider and source mux
  logic [15:0] rate_cnt_reg;
  logic [15:0] rate_div;
  logic [1:0] wav_phase;
  logic [2:0] wav_src;
  logic sample_take;
  assign rate_div = 16'(RATE_BASE_DIV << waveform_mode_reg[`WEM_WAV_RATE_LSB +: 2]);
  assign wav_phase = waveform_mode_reg[1:0];
  assign wav_src = waveform_mode_reg[`WEM_WAV_SRC_LSB +: 3];
  assign sample_take = (rate_cnt_reg == 16'h0000) && (wav_phase < 2'(PHASES));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_reg <= 16'h0000;
    end else if (rate_cnt_reg == 16'h0000) begin
      rate_cnt_reg <= rate_div - 16'h0001;
    end else begin
      rate_cnt_reg <= rate_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waveform_result <= 24'h000000;
    end else if (sample_take) begin
      if (wav_src == `WEM_WAV_SRC_VOLT) begin
        waveform_result <= {{8{lp_reg[wav_phase][15]}}, lp_reg[wav_phase]};
      end else begin
        waveform_result <= adc[wav_phase].current;
      end
    end
  end

  // status flags: hardware set wins over a clear in the same cycle
  always_comb begin
    status_set = '0;
    status_set[`WEM_ST_OVERCUR_BIT] = |over_hit;
    status_set[`WEM_ST_CROSS_LSB +: PHASES] = cross_rise;
    status_set[`WEM_ST_READY_BIT] = sample_take;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else if (status_clear) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      // sticky flags keep the line low until the clearing read
      irq_n <= ~|(status_reg & mask_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integrator_on <= 1'b0;
    end else begin
      integrator_on <= gain_reg[`WEM_GAIN_INTEG_BIT];
    end
  end

  // AXI4-Lite write side
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_ok;
  assign wr_addr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr[7:0] : aw_addr_reg;
  assign wr_data = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data_reg;
  assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
    && (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
  assign wr_ok = wr_addr inside {`WEM_OFF_GAIN, `WEM_OFF_MEASMODE, `WEM_OFF_WAVEMODE,
    `WEM_OFF_LINEMODE, `WEM_OFF_THRESH, `WEM_OFF_MASK, `WEM_OFF_PEAKCYC};
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    bvalid_next = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) aw_held_next = 1'b1;
    if (s_axi_wvalid && s_axi_wready) w_held_next = 1'b1;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WEM_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `WEM_AXI_OKAY : `WEM_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // readies registered from next state so the ports come straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
    end
  end

  logic [3:0] wr_strb;
  assign wr_strb = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : w_strb_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_reg <= 8'h00;
      measurement_mode_reg <= 8'h00;
      waveform_mode_reg <= 8'h00;
      line_cycle_mode_reg <= 8'h00;
      overcurrent_threshold <= 8'hFF;
      peak_cycles_reg <= `WEM_PEAKCYC_RESET;
      mask_reg <= '0;
    end else if (do_write && wr_ok) begin
      if (wr_strb[0]) begin
        case (wr_addr)
          `WEM_OFF_GAIN: gain_reg <= wr_data[7:0];
          `WEM_OFF_MEASMODE: measurement_mode_reg <= wr_data[7:0];
          `WEM_OFF_WAVEMODE: waveform_mode_reg <= wr_data[7:0];
          `WEM_OFF_LINEMODE: line_cycle_mode_reg <= wr_data[7:0];
          `WEM_OFF_THRESH: overcurrent_threshold <= wr_data[7:0];
          `WEM_OFF_PEAKCYC: peak_cycles_reg <= wr_data[7:0];
          `WEM_OFF_MASK: mask_reg[7:0] <= wr_data[7:0];
          default: ;
        endcase
      end
      if (wr_addr == `WEM_OFF_MASK && wr_strb[1]) mask_reg[15:8] <= wr_data[15:8];
      if (wr_addr == `WEM_OFF_MASK && wr_strb[2]) mask_reg[16] <= wr_data[16];
    end
  end

  // AXI4-Lite read side; waveform bytes read as three words, MSB first
  wem_rd_state_type rd_state_reg;
  logic [31:0] rd_value;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0])
      `WEM_OFF_GAIN: rd_value = {24'h000000, gain_reg};
      `WEM_OFF_MEASMODE: rd_value = {24'h000000, measurement_mode_reg};
      `WEM_OFF_WAVEMODE: rd_value = {24'h000000, waveform_mode_reg};
      `WEM_OFF_LINEMODE: rd_value = {24'h000000, line_cycle_mode_reg};
      `WEM_OFF_THRESH: rd_value = {24'h000000, overcurrent_threshold};
      `WEM_OFF_MASK: rd_value = {15'h0000, mask_reg};
      `WEM_OFF_STATUS: rd_value = {15'h0000, status_reg};
      `WEM_OFF_STATUS_CLR: rd_value = {15'h0000, status_reg};
      `WEM_OFF_WAVE_HI: rd_value = {24'h000000, waveform_result[23:16]};
      `WEM_OFF_WAVE_MID: rd_value = {24'h000000, waveform_result[15:8]};
      `WEM_OFF_WAVE_LO: rd_value = {24'h000000, waveform_result[7:0]};
      `WEM_OFF_CUR_PEAK: rd_value = {24'h000000, current_peak_value};
      `WEM_OFF_VOLT_PEAK: rd_value = {24'h000000, voltage_peak_value};
      `WEM_OFF_PEAKCYC: rd_value = {24'h000000, peak_cycles_reg};
      default: begin
        rd_value = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign status_clear = s_axi_arvalid && s_axi_arready
    && (s_axi_araddr[7:0] == `WEM_OFF_STATUS_CLR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= WEM_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WEM_AXI_OKAY;
    end else begin
      case (rd_state_reg)
        WEM_RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? `WEM_AXI_OKAY : `WEM_AXI_SLVERR;
            rd_state_reg <= WEM_RD_RESP;
          end
        end
        WEM_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state_reg <= WEM_RD_IDLE;
          end
        end
        default: rd_state_reg <= WEM_RD_IDLE;
      endcase
    end
  end
endmodule

// File: tb/wem_monitor_asserts.sv
// port-level assertions for the waveform monitor
`timescale 1ns/100ps
module wem_monitor_asserts import wem_pkg::*; #(
  parameter int PHASES = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire wem_sample_type adc_a,
  input wire wem_sample_type adc_b,
  input wire wem_sample_type adc_c,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic integrator_on,
  input wire logic [PHASES-1:0] crossing_pulse,
  input wire logic irq_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence gain_taken;
    both_taken ##0 (s_axi_awaddr[7:0] == 8'h00 && s_axi_wstrb[0]);
  endsequence
  // nothing in flight that could lawfully move the interrupt, clear reads included
  sequence bus_quiet;
    s_axi_arready && $past(s_axi_arready) && !s_axi_arvalid && !s_axi_rvalid
      && !s_axi_awvalid && !s_axi_bvalid;
  endsequence
  a_integ_reset: assert property (disable iff (1'b0) !aresetn |=> !integrator_on)
    else $error("integrator on after reset");
  a_irq_reset: assert property (disable iff (1'b0) !aresetn |=> irq_n)
    else $error("interrupt low after reset");
  a_integ_follow: assert property (
    gain_taken |=> ##1 integrator_on == $past(s_axi_wdata[7], 2))
    else $error("integrator does not follow gain bit");
  a_write_answer: assert property (both_taken |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  a_irq_holds: assert property (!irq_n ##0 bus_quiet |=> !irq_n)
    else $error("interrupt released without clear read");
  a_cross_sample: assert property (
    (crossing_pulse & ~$past({adc_c.valid, adc_b.valid, adc_a.valid})) == '0)
    else $error("crossing pulse without a sample of that phase");
  a_cross_single: assert property (
    |crossing_pulse |=> (crossing_pulse & $past(crossing_pulse)) == '0)
    else $error("crossing pulse longer than one cycle");
endmodule

bind wem_monitor wem_monitor_asserts #(.PHASES(PHASES)) u_wem_monitor_asserts (
  .aclk(aclk), .aresetn(aresetn), .adc_a(adc_a), .adc_b(adc_b), .adc_c(adc_c),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .integrator_on(integrator_on), .crossing_pulse(crossing_pulse), .irq_n(irq_n));

// File: tb/wem_adc_model.sv
// converter front-end stand-in that delivers one sample per call
`timescale 1ns/100ps
module wem_adc_model import wem_pkg::*; (
  input wire logic aclk,
  output wem_sample_type adc_a,
  output wem_sample_type adc_b,
  output wem_sample_type adc_c
);
  initial begin
    adc_a = '0;
    adc_b = '0;
    adc_c = '0;
  end
  // payload inverts once valid drops, so a stale word never passes for data
  task automatic put(input int p, input logic [23:0] i, input logic [15:0] v);
    @(posedge aclk);
    if (p == 0) adc_a <= '{i, v, 1'b1};
    else if (p == 1) adc_b <= '{i, v, 1'b1};
    else adc_c <= '{i, v, 1'b1};
    @(posedge aclk);
    if (adc_a.valid) adc_a <= ~adc_a;
    if (adc_b.valid) adc_b <= ~adc_b;
    if (adc_c.valid) adc_c <= ~adc_c;
  endtask
endmodule

// File: tb/test_waveform_event_monitor.sv
// self-checking bench for the waveform event monitor
`timescale 1ns/100ps
module test_waveform_event_monitor import wem_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wem_sample_type adc_a, adc_b, adc_c;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, integrator_on, irq_n;
  logic [1:0] bresp, rresp, r;
  logic [2:0] crossing_pulse;
  int num_errors = 0, total_checks = 0, cyc = 0, cross_a = 0, cross_b = 0;
  always #20 aclk = ~aclk;
  wem_adc_model u_adc (.aclk(aclk), .adc_a(adc_a), .adc_b(adc_b), .adc_c(adc_c));
  // short rate divider keeps the waveform sampling loop brief
  wem_monitor #(.RATE_BASE_DIV(4)) u_wem_monitor (
    .aclk(aclk), .aresetn(aresetn), .adc_a(adc_a), .adc_b(adc_b), .adc_c(adc_c),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .integrator_on(integrator_on), .crossing_pulse(crossing_pulse), .irq_n(irq_n));
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (crossing_pulse[0] === 1'b1) cross_a <= cross_a + 1;
    if (crossing_pulse[1] === 1'b1) cross_b <= cross_b + 1;
    if (cyc == 60000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    chk(d & m, e);
  endtask
  task automatic t_reset;
    @(negedge aclk);
    chk(integrator_on, 0);
    chk(irq_n, 1);
    rd(8'h10, 32'hFF, 32'hFF);
    rd(8'h34, 32'hFF, 32'h04);
    rd(8'h3C, 32'hFFFFFFFF, 32'h0);
    chk(r, 2'b10);
    wr(8'h18, 32'h0, 2'b10);
  endtask
  task automatic t_integ;
    wr(8'h00, 32'h80, 2'b00);
    @(negedge aclk);
    chk(integrator_on, 1);
    wr(8'h00, 32'h7F, 2'b00);
    @(negedge aclk);
    chk(integrator_on, 0);
  endtask
  // only phase B is watched; phase A above the limit must be ignored
  task automatic t_overcur;
    wr(8'h10, 32'h40, 2'b00);
    wr(8'h04, 32'h40, 2'b00);
    wr(8'h14, 32'h8000, 2'b00);
    rd(8'h1C, 32'h0, 32'h0);
    u_adc.put(0, 24'h104000, 16'h0);
    u_adc.put(1, 24'h100000, 16'h0);
    rd(8'h18, 32'h8000, 32'h0);
    chk(irq_n, 1);
    u_adc.put(1, 24'hEFC000, 16'h0);
    rd(8'h18, 32'h8000, 32'h8000);
    @(negedge aclk);
    chk(irq_n, 0);
    rd(8'h1C, 32'h0, 32'h0);
    rd(8'h18, 32'h8000, 32'h0);
    chk(irq_n, 1);
  endtask
  task automatic win(input logic [7:0] pk);
    int n0;
    int n1;
    n0 = cross_a;
    n1 = cross_b;
    wr(8'h14, 32'h200, 2'b00);
    rd(8'h1C, 32'h0, 32'h0);
    for (int k = 0; k < 8; k++) begin
      repeat (40) begin
        u_adc.put(0, 24'h0C8000, k[0] ? 16'h3E80 : 16'hC180);
        u_adc.put(1, 24'h200000, 16'h0000);
      end
    end
    @(negedge aclk);
    chk(cross_a - n0, 4);
    chk(cross_b - n1, 0);
    chk(irq_n, 0);
    rd(8'h18, 32'hE00, 32'h200);
    rd(8'h2C, 32'hFF, {24'h0, pk});
    rd(8'h1C, 32'h0, 32'h0);
    rd(8'h18, 32'hE00, 32'h0);
  endtask
  task automatic t_wave;
    int n;
    repeat (60) u_adc.put(0, 24'h0, 16'hC180);
    wr(8'h14, 32'h10000, 2'b00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, {25'h0, k[1:0], 5'b00100}, 2'b00);
      rd(8'h1C, 32'h0, 32'h0);
      n = 0;
      while (irq_n !== 1'b0 && n < 200) begin
        @(negedge aclk);
        n++;
      end
      chk(irq_n, 0);
    end
    rd(8'h20, 32'hFF, 32'hFF);
    rd(8'h24, 32'h80, 32'h80);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_integ();
    t_overcur();
    wr(8'h0C, 32'h1, 2'b00);
    wr(8'h04, 32'h04, 2'b00);
    win(8'h32);
    wr(8'h04, 32'h0C, 2'b00);
    win(8'h80);
    t_wave();
    summarize();
  end
endmodule
